// >>> core/sar_host.sv
// Host controller that triggers conversions and reads results over the parallel bus
// Function
// [RULE_01] Trigger fall starts conversion, busy within 40ns
// [RULE_02] Busy high exactly while converting
// [RULE_03] Conversion ends by 610ns, busy under 630ns
// [RULE_04] Host keeps 150ns acquisition before next trigger
// [RULE_05] Trigger low and high each 20ns minimum
// [RULE_06] Result valid no later than busy fall
// [RULE_07] Host may read right after busy falls
// [RULE_08] No read-pin changes within 40ns of trigger
// [RULE_09] Last read ends 50ns before next trigger
// [RULE_10] Select around strobe, never inside it
// [RULE_11] Strobe low 50ns, high 20ns minimum
// [RULE_12] Device drives bus within 30ns of read
// [RULE_13] Device releases bus within 30ns
// [RULE_14] Byte select folds low byte onto top
// [RULE_15] Byte select change settles within 30ns
// [RULE_16] Reset aborts conversion, clears result
// [RULE_17] Capture after busy fall, full or two bytes
`timescale 1ns/1ps
module sar_host #(
  parameter int unsigned FIFO_DEPTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // User side
  input wire logic start_i,
  input wire logic byte_mode_i,
  output logic busy_o,
  output logic timeout_o,
  output logic [sar_pkg::DATA_W-1:0] sample_data_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  // Converter pins
  output logic conversion_trigger_n_o,
  output logic chip_select_n_o,
  output logic read_n_o,
  output logic byte_sel_o,
  output logic adc_reset_n_o,
  input wire logic adc_busy_i,
  input wire logic [sar_pkg::DATA_W-1:0] result_bus_i
);
  sar_pkg::sar_state_e state;
  sar_pkg::sar_state_e next_state;
  logic [sar_pkg::CNT_W-1:0] cnt;
  logic busy_meta;
  logic busy_sync;
  logic [sar_pkg::DATA_W-1:0] bus_meta;
  logic [sar_pkg::DATA_W-1:0] bus_sync;
  logic [sar_pkg::DATA_W-1:0] result;
  logic byte_pass;
  logic byte_mode;
  logic push_valid;
  logic buf_ready;
  logic [sar_pkg::DATA_W-1:0] buf_data;
  logic buf_valid;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
      bus_meta <= '0;
      bus_sync <= '0;
    end else begin
      busy_meta <= adc_busy_i;
      busy_sync <= busy_meta;
      bus_meta <= result_bus_i;
      bus_sync <= bus_meta;
    end
  end

  // ------------------------------------------------------------
  // Sequencer decode
  // ------------------------------------------------------------
  localparam logic [sar_pkg::CNT_W-1:0] TRIG_N = sar_pkg::CNT_W'(sar_pkg::C_TRIG_PULSE);
  localparam logic [sar_pkg::CNT_W-1:0] HOLD_N = sar_pkg::CNT_W'(sar_pkg::C_HOLD_AFTER_TRIG);
  localparam logic [sar_pkg::CNT_W-1:0] RISE_N = sar_pkg::CNT_W'(sar_pkg::C_BUSY_RISE);
  localparam logic [sar_pkg::CNT_W-1:0] TOUT_N = sar_pkg::CNT_W'(sar_pkg::C_BUSY_TIMEOUT);
  localparam logic [sar_pkg::CNT_W-1:0] RDL_N = sar_pkg::CNT_W'(sar_pkg::C_RD_LOW + 2);
  localparam logic [sar_pkg::CNT_W-1:0] RDH_N = sar_pkg::CNT_W'(sar_pkg::C_RD_HIGH);
  localparam logic [sar_pkg::CNT_W-1:0] BSET_N = sar_pkg::CNT_W'(sar_pkg::C_BYTE_SETTLE);
  localparam int unsigned GAP_MIN = (sar_pkg::C_ACQ > sar_pkg::C_READ_TO_TRIG) ?
    sar_pkg::C_ACQ : sar_pkg::C_READ_TO_TRIG;
  localparam logic [sar_pkg::CNT_W-1:0] GAP_N = sar_pkg::CNT_W'(GAP_MIN + sar_pkg::C_DIS);

  wire cnt_done = (cnt == '0);
  wire [sar_pkg::CNT_W-1:0] cnt_dec = cnt - 1'b1;
  wire busy_lost = (state == sar_pkg::SAR_WAIT_BUSY) && cnt_done && !busy_sync;
  wire conv_stuck = (state == sar_pkg::SAR_CONV) && cnt_done && busy_sync;
  wire second_byte = byte_mode && byte_pass;
  wire first_byte_read = (state == sar_pkg::SAR_RD_HIGH) && byte_mode && !byte_pass;

  always_comb begin
    next_state = state;
    case (state)
      sar_pkg::SAR_IDLE: begin
        if (start_i && buf_ready) next_state = sar_pkg::SAR_TRIG_LOW;
      end
      // [RULE_05] Trigger low width
      sar_pkg::SAR_TRIG_LOW: begin
        if (cnt_done) next_state = sar_pkg::SAR_WAIT_BUSY;
      end
      // [RULE_01] Expect busy rise
      sar_pkg::SAR_WAIT_BUSY: begin
        if (busy_sync && cnt_done) next_state = sar_pkg::SAR_CONV;
        else if (busy_lost) next_state = sar_pkg::SAR_GAP;
      end
      // [RULE_07] Read right after fall
      sar_pkg::SAR_CONV: begin
        if (!busy_sync) next_state = sar_pkg::SAR_RD_LOW;
        else if (conv_stuck) next_state = sar_pkg::SAR_GAP;
      end
      sar_pkg::SAR_RD_LOW: begin
        if (cnt_done) next_state = sar_pkg::SAR_RD_HIGH;
      end
      sar_pkg::SAR_RD_HIGH: begin
        if (cnt_done && first_byte_read) next_state = sar_pkg::SAR_BYTE_SET;
        else if (cnt_done) next_state = sar_pkg::SAR_PUSH;
      end
      // [RULE_15] Settle after byte toggle
      sar_pkg::SAR_BYTE_SET: begin
        if (cnt_done) next_state = sar_pkg::SAR_RD_LOW;
      end
      sar_pkg::SAR_PUSH: begin
        next_state = sar_pkg::SAR_GAP;
      end
      // [RULE_04] Acquisition and read hold
      sar_pkg::SAR_GAP: begin
        if (cnt_done) next_state = sar_pkg::SAR_IDLE;
      end
      default: next_state = sar_pkg::SAR_IDLE;
    endcase
  end

  // Counter load per entered state
  logic [sar_pkg::CNT_W-1:0] next_cnt;
  always_comb begin
    next_cnt = cnt_done ? cnt : cnt_dec;
    if (next_state != state) begin
      case (next_state)
        sar_pkg::SAR_TRIG_LOW: next_cnt = TRIG_N;
        // [RULE_08] Pins frozen after trigger
        sar_pkg::SAR_WAIT_BUSY: next_cnt = (HOLD_N > RISE_N) ? HOLD_N : RISE_N;
        sar_pkg::SAR_CONV: next_cnt = TOUT_N;
        // [RULE_11] Strobe low time
        sar_pkg::SAR_RD_LOW: next_cnt = RDL_N;
        sar_pkg::SAR_RD_HIGH: next_cnt = RDH_N;
        sar_pkg::SAR_BYTE_SET: next_cnt = BSET_N;
        // [RULE_09] Read end to trigger
        sar_pkg::SAR_GAP: next_cnt = GAP_N;
        default: next_cnt = '0;
      endcase
    end
  end

  // [RULE_14] Merge fold-back bytes
  wire [sar_pkg::DATA_W-1:0] next_result = second_byte ?
    {result[sar_pkg::DATA_W-1:sar_pkg::BYTE_W], bus_sync[sar_pkg::DATA_W-1:sar_pkg::BYTE_W]} :
    byte_mode ? {bus_sync[sar_pkg::DATA_W-1:sar_pkg::BYTE_W], {sar_pkg::BYTE_W{1'b0}}} : bus_sync;
  // Sample at end of strobe low, two cycles past the longer of low and enable time for the synchroniser
  wire sample_now = (state == sar_pkg::SAR_RD_LOW) && cnt_done;
  wire in_read = (next_state == sar_pkg::SAR_RD_LOW);
  wire cs_active = (next_state == sar_pkg::SAR_RD_LOW) || (next_state == sar_pkg::SAR_RD_HIGH) ||
    (next_state == sar_pkg::SAR_BYTE_SET);
  // [RULE_08] Byte select parked early
  // Dropped at push so it never moves on the edge that lowers the next trigger
  wire next_byte_pass = (next_state == sar_pkg::SAR_BYTE_SET) ? 1'b1 :
    (next_state == sar_pkg::SAR_PUSH) ? 1'b0 : byte_pass;

  // ------------------------------------------------------------
  // State and pin registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= sar_pkg::SAR_IDLE;
      cnt <= '0;
      byte_pass <= 1'b0;
      byte_mode <= 1'b0;
      result <= sar_pkg::RESULT_RESET;
      push_valid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      byte_pass <= next_byte_pass;
      // Mode latched per conversion so a mid-read change cannot split a word
      if (next_state == sar_pkg::SAR_TRIG_LOW) byte_mode <= byte_mode_i;
      // [RULE_17] Capture after busy fall
      if (sample_now) result <= next_result;
      push_valid <= (next_state == sar_pkg::SAR_PUSH);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conversion_trigger_n_o <= 1'b1;
      chip_select_n_o <= 1'b1;
      read_n_o <= 1'b1;
      byte_sel_o <= 1'b0;
      // [RULE_16] Hold converter in reset
      adc_reset_n_o <= 1'b0;
      busy_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      adc_reset_n_o <= 1'b1;
      conversion_trigger_n_o <= (next_state != sar_pkg::SAR_TRIG_LOW);
      // [RULE_10] Select wraps strobe
      chip_select_n_o <= !cs_active;
      read_n_o <= !in_read;
      byte_sel_o <= next_byte_pass && byte_mode;
      busy_o <= (next_state != sar_pkg::SAR_IDLE);
      // Sticky error until next start; the converter is pulsed into reset below
      if (busy_lost || conv_stuck) timeout_o <= 1'b1;
      else if (next_state == sar_pkg::SAR_TRIG_LOW) timeout_o <= 1'b0;
      if (busy_lost || conv_stuck) adc_reset_n_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Result buffer and registered user outputs
  // ------------------------------------------------------------
  wire out_take = !sample_valid_o || sample_ready_i;

  sar_skid_buf #(
    .WIDTH(sar_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_buf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_data_i(result),
    .in_valid_i(push_valid),
    .in_ready_o(buf_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(out_take)
  );

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_valid_o <= 1'b0;
      sample_data_o <= '0;
    end else if (out_take) begin
      sample_valid_o <= buf_valid;
      if (buf_valid) sample_data_o <= buf_data;
    end
  end
endmodule : sar_host

// >>> common/sar_pkg.sv
// Constants for the host-side converter controller
package sar_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Device timing in nanoseconds
  localparam int unsigned T_BUSY_RISE_NS = 40;
  localparam int unsigned T_CONV_NS = 610;
  localparam int unsigned T_BUSY_HIGH_NS = 630;
  localparam int unsigned T_ACQ_NS = 150;
  localparam int unsigned T_TRIG_PULSE_NS = 20;
  localparam int unsigned T_HOLD_AFTER_TRIG_NS = 40;
  localparam int unsigned T_READ_TO_TRIG_NS = 50;
  localparam int unsigned T_RD_LOW_NS = 50;
  localparam int unsigned T_RD_HIGH_NS = 20;
  localparam int unsigned T_EN_NS = 30;
  localparam int unsigned T_BYTE_SETTLE_NS = 30;
  localparam int unsigned T_DIS_NS = 30;
  // Least times round up, longest times round down, none below one cycle
  localparam int unsigned C_TRIG_PULSE = (T_TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_HOLD_AFTER_TRIG =
    (T_HOLD_AFTER_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_ACQ = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_READ_TO_TRIG = (T_READ_TO_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_RD_HIGH = (T_RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data must be valid before sampling: wait the longer of low time and enable time
  localparam int unsigned C_RD_LOW =
    ((T_RD_LOW_NS > T_EN_NS ? T_RD_LOW_NS : T_EN_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_BYTE_SETTLE = (T_BYTE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned C_DIS = (T_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Watchdog on busy: beyond the longest busy time plus sync delay the conversion is lost
  localparam int unsigned C_BUSY_TIMEOUT = T_BUSY_HIGH_NS / CLK_PERIOD_NS + 4;
  localparam int unsigned C_BUSY_RISE = T_BUSY_RISE_NS / CLK_PERIOD_NS + 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [8:0] {
    SAR_IDLE = 9'h001,
    SAR_TRIG_LOW = 9'h002,
    SAR_WAIT_BUSY = 9'h004,
    SAR_CONV = 9'h008,
    SAR_RD_LOW = 9'h010,
    SAR_RD_HIGH = 9'h020,
    SAR_BYTE_SET = 9'h040,
    SAR_PUSH = 9'h080,
    SAR_GAP = 9'h100
  } sar_state_e;
endpackage : sar_pkg

// >>> core/sar_skid_buf.sv
// Two-entry valid/ready buffer for converted results
`timescale 1ns/1ps
module sar_skid_buf #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  wire push = in_valid_i && (count != DEPTH_C);
  wire pop = out_ready_i && (count != '0);
  wire [PW-1:0] next_wr_ptr = (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;

  assign in_ready_o = (count != DEPTH_C);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule : sar_skid_buf

// >>> tb/sar_host_properties.sv
// Pin protocol checker for the host converter controller
`timescale 1ns/1ps
module sar_host_checker (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic conversion_trigger_n_o,
  input wire logic chip_select_n_o,
  input wire logic read_n_o,
  input wire logic byte_sel_o,
  input wire logic adc_reset_n_o,
  input wire logic adc_busy_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Idle counters, saturating so long gaps never wrap
  // ----------------------------------------
  logic [4:0] lo_cnt;
  logic [3:0] hi_cnt;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_cnt <= 5'h1F;
      hi_cnt <= 4'hF;
    end else begin
      lo_cnt <= adc_busy_i ? 5'h00 : lo_cnt + {4'h0, lo_cnt != 5'h1F};
      hi_cnt <= !read_n_o ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_trig;
    $fell(conversion_trigger_n_o);
  endsequence
  sequence s_still;
    $stable(read_n_o) && $stable(chip_select_n_o) && $stable(byte_sel_o);
  endsequence
  property p_trig_low;
    s_trig |-> !conversion_trigger_n_o [*2];
  endproperty
  a_trig_low: assert property (p_trig_low) else $error("trigger low short");
  property p_trig_high;
    $rose(conversion_trigger_n_o) |-> conversion_trigger_n_o [*2];
  endproperty
  a_trig_high: assert property (p_trig_high) else $error("trigger high short");
  property p_acq;
    s_trig |-> lo_cnt >= 5'd15;
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition short");
  property p_hold;
    s_trig |-> s_still [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("read pins moved");
  property p_rd_gap;
    s_trig |-> hi_cnt >= 4'd5;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read too near trigger");
  property p_cs;
    !read_n_o |-> !chip_select_n_o;
  endproperty
  a_cs: assert property (p_cs) else $error("strobe outside select");
  property p_rd_low;
    $fell(read_n_o) |-> !read_n_o [*5];
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("strobe low short");
  property p_rd_high;
    $rose(read_n_o) |-> read_n_o [*2];
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("strobe high short");
  property p_rd_idle;
    $fell(read_n_o) |-> !adc_busy_i;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read while busy");
  property p_rst;
    $fell(adc_reset_n_o) |=> adc_reset_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pulse long");
endmodule : sar_host_checker
bind sar_host sar_host_checker chk_u (.clk_sys_i, .reset_n_i, .conversion_trigger_n_o,
  .chip_select_n_o, .read_n_o, .byte_sel_o, .adc_reset_n_o, .adc_busy_i);

// >>> tb/sar_adc_model.sv
// Behavioural model of the converter on the parallel bus
`timescale 1ns/1ps
module sar_adc_model (
  input wire logic trig_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic byte_i,
  input wire logic rst_n_i,
  input wire logic mute_i,
  input wire logic stuck_i,
  input wire logic [15:0] value_i,
  output logic busy_o,
  output logic [15:0] bus_o
);
  logic [15:0] result = 16'h0000;
  int gen = 0;
  wire sel = !cs_n_i && !rd_n_i;
  wire [15:0] shown = byte_i ? {result[7:0], 8'hFF} : result;
  initial busy_o = 1'b0;
  initial bus_o = 16'h5A5A;
  always @(negedge trig_n_i) begin : conv
    int my_gen;
    my_gen = gen;
    if (!busy_o && !mute_i && rst_n_i) begin
      #30 busy_o = (my_gen == gen);
      #580;
      // A stuck converter keeps busy high until it is reset
      if (my_gen == gen && !stuck_i) begin
        result = value_i;
        busy_o = 1'b0;
      end
    end
  end
  always @(negedge rst_n_i) begin
    gen++;
    busy_o = 1'b0;
    result = 16'h0000;
  end
  always @(sel or shown) bus_o <= #20 (sel ? shown : ~bus_o);
endmodule : sar_adc_model

// >>> tb/sar_host_bench.sv
// Self-checking bench for the host converter controller
`timescale 1ns/1ps
`define CHK(w, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", w, e, g); end end
module sar_host_bench;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic byte_mode_i = 1'b0;
  logic sample_ready_i = 1'b0;
  logic mute = 1'b0;
  logic stuck = 1'b0;
  logic [15:0] value = 16'h0000;
  logic busy_o, timeout_o, sample_valid_o, conversion_trigger_n_o, chip_select_n_o;
  logic read_n_o, byte_sel_o, adc_reset_n_o, adc_busy_i;
  logic [15:0] sample_data_o, result_bus_i;
  int mismatches = 0;
  int num_checks = 0;
  int pulses = 0;
  logic [15:0] vals [4] = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h3C96};
  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(negedge adc_reset_n_o) if (reset_n_i) pulses++;
  sar_host dut_u (.clk_sys_i, .reset_n_i, .start_i, .byte_mode_i, .busy_o, .timeout_o,
    .sample_data_o, .sample_valid_o, .sample_ready_i, .conversion_trigger_n_o,
    .chip_select_n_o, .read_n_o, .byte_sel_o, .adc_reset_n_o, .adc_busy_i, .result_bus_i);
  sar_adc_model model_u (.trig_n_i(conversion_trigger_n_o), .cs_n_i(chip_select_n_o),
    .rd_n_i(read_n_o), .byte_i(byte_sel_o), .rst_n_i(adc_reset_n_o), .mute_i(mute),
    .stuck_i(stuck),
    .value_i(value), .busy_o(adc_busy_i), .bus_o(result_bus_i));
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // Bounded wait: 0 valid, 1 idle, 2 timeout flag
  task automatic wait_until(input int which, input int bound);
    int n;
    n = 0;
    while (!((which == 0 && sample_valid_o === 1'b1) || (which == 1 && busy_o === 1'b0)
        || (which == 2 && timeout_o === 1'b1))) begin
      @(negedge clk_sys_i);
      n++;
      if (n > bound) begin
        mismatches++;
        $display("Error wait %0d expected done seen hang", which);
        results();
      end
    end
  endtask : wait_until
  task automatic convert(input logic mode, input logic [15:0] v);
    wait_until(1, 200);
    value = v;
    byte_mode_i = mode;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
  endtask : convert
  task automatic take(input logic [15:0] exp);
    wait_until(0, 400);
    `CHK("sample", exp, sample_data_o)
    sample_ready_i = 1'b1;
    @(negedge clk_sys_i);
    sample_ready_i = 1'b0;
    @(negedge clk_sys_i);
  endtask : take
  task automatic t_modes();
    for (int m = 0; m < 2; m++) begin
      foreach (vals[i]) begin
        convert(m[0], vals[i]);
        take(vals[i]);
      end
    end
  endtask : t_modes
  // Consumer stalls: output register and both buffer entries full, fourth start refused
  task automatic t_stall();
    convert(1'b0, 16'h1234);
    convert(1'b1, 16'hFEDC);
    convert(1'b0, 16'hBEEF);
    wait_until(1, 200);
    start_i = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    `CHK("busy_full", 1'b0, busy_o)
    start_i = 1'b0;
    take(16'h1234);
    take(16'hFEDC);
    take(16'hBEEF);
  endtask : t_stall
  task automatic t_abort();
    convert(1'b0, 16'h5555);
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    @(negedge clk_sys_i);
    `CHK("adc_rst", 1'b0, adc_reset_n_o)
    `CHK("busy_rst", 1'b0, busy_o)
    `CHK("trig_rst", 1'b1, conversion_trigger_n_o)
    `CHK("rd_rst", 1'b1, read_n_o)
    repeat (7) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    `CHK("valid_rst", 1'b0, sample_valid_o)
    `CHK("adc_rst_rel", 1'b1, adc_reset_n_o)
    // Let the aborted conversion's timer in the model run out before the next trigger
    repeat (64) @(negedge clk_sys_i);
  endtask : t_abort
  task automatic t_timeout();
    int p;
    p = pulses;
    mute = 1'b1;
    convert(1'b0, 16'h0F0F);
    wait_until(2, 200);
    repeat (3) @(negedge clk_sys_i);
    `CHK("adc_pulse", 1, pulses - p)
    mute = 1'b0;
    convert(1'b0, 16'hC33C);
    take(16'hC33C);
    `CHK("timeout_clr", 1'b0, timeout_o)
    // Busy that never falls must end in the long-conversion timeout
    p = pulses;
    stuck = 1'b1;
    convert(1'b0, 16'h6996);
    wait_until(2, 200);
    repeat (3) @(negedge clk_sys_i);
    `CHK("adc_pulse_stuck", 1, pulses - p)
    `CHK("no_word", 1'b0, sample_valid_o)
    stuck = 1'b0;
    convert(1'b0, 16'h6996);
    take(16'h6996);
    `CHK("timeout_clr2", 1'b0, timeout_o)
  endtask : t_timeout
  initial begin
    repeat (8) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    t_modes();
    t_stall();
    t_abort();
    t_timeout();
    results();
  end
endmodule : sar_host_bench
